// ==== wqos_pkg.sv ====
// Package of constants and types for the queue occupancy status block
package wqos_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [4:0] WQOS_OFF_HANDLE = 5'h10;
   localparam logic [4:0] WQOS_OFF_CTRL   = 5'h14;
   localparam logic [4:0] WQOS_OFF_STAT   = 5'h18;
   localparam logic [4:0] WQOS_OFF_TAIL   = 5'h1C;
   // ----------------------------------------
   // Field positions and widths
   // ----------------------------------------
   localparam int WQOS_CNT_W     = 16;
   localparam int WQOS_BIT_EN    = 16;
   localparam int WQOS_BIT_TSEL  = 16;
   localparam int WQOS_BIT_GEN   = 16;
   localparam int WQOS_BIT_MODE  = 29;
   localparam int WQOS_STATE_LSB = 30;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] WQOS_RST_LIMIT  = 16'h0000;
   localparam logic [15:0] WQOS_RST_HANDLE = 16'h0000;
   localparam logic [15:0] WQOS_RST_COUNT  = 16'h0000;
   // ----------------------------------------
   // Queue states
   // ----------------------------------------
   typedef enum logic [1:0] {
      WQOS_ST_DISABLED = 2'h0,
      WQOS_ST_ENABLED  = 2'h1,
      WQOS_ST_DRAINING = 2'h2,
      WQOS_ST_UNUSED   = 2'h3
   } wqos_state_t;
endpackage

// ==== wqos_occ_if.sv ====
// Interface carrying occupancy events and count between modules
`timescale 1ns/1ps
interface wqos_occ_if #(parameter int CNT_W = 16);
   logic             inc;
   logic             dec;
   logic [CNT_W-1:0] count;
   modport ctrl (output inc, output dec, input count);
   modport cnt  (input inc, input dec, output count);
endinterface

// ==== wqos_occ_counter.sv ====
// Occupancy counter of the work queue
`timescale 1ns/1ps
module wqos_occ_counter #(
   parameter int CNT_W = 16
) (
   input  wire logic core_clk_i,
   input  wire logic srst_i,
   wqos_occ_if.cnt   occ
);
   import wqos_pkg::*;

   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   wire              at_max  = &count_ff;
   wire              at_zero = ~|count_ff;
   wire              do_inc  = occ.inc & ~occ.dec & ~at_max;
   wire              do_dec  = occ.dec & ~occ.inc & ~at_zero;

   // ----------------------------------------
   // Entry count
   // ----------------------------------------
   assign nxt_count = do_inc ? count_ff + 1'b1 :
                      do_dec ? count_ff - 1'b1 : count_ff;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         count_ff <= CNT_W'(WQOS_RST_COUNT);
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign occ.count = count_ff;
endmodule // wqos_occ_counter

// ==== wqos_top.sv ====
// Occupancy interrupt, state and status registers of one work queue
`timescale 1ns/1ps
module wqos_top #(
   parameter int CNT_W = 16
) (
   input  wire logic                  core_clk_i,
   input  wire logic                  srst_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   input  wire logic [4:0]            reg_addr_i,
   input  wire logic [31:0]           reg_wdata_i,
   output logic      [31:0]           reg_rdata_o,
   output logic                       reg_rvalid_o,
   input  wire wqos_pkg::wqos_state_t wq_state_i,
   input  wire logic                  occ_intr_sup_i,
   input  wire logic                  occ_sup_i,
   input  wire logic                  cfg_sup_i,
   input  wire logic                  mode_fixed_i,
   input  wire logic                  sub_valid_i,
   input  wire logic                  sub_is_enq_i,
   input  wire logic                  dispatch_i,
   output logic                       sub_accept_o,
   output logic                       sub_retry_o,
   output logic                       occ_intr_o,
   output logic      [15:0]           intr_handle_o,
   output logic                       intr_table_sel_o
);
   import wqos_pkg::*;

   wqos_occ_if #(.CNT_W(CNT_W)) occ ();

   logic        en_ff;
   logic [15:0] limit_ff;
   logic        gen_ff;
   logic [15:0] handle_ff;
   logic        tsel_ff;
   logic [31:0] rdata_ff;
   logic        rvalid_ff;
   logic        accept_ff;
   logic        retry_ff;
   logic        intr_ff;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire st_dis  = (wq_state_i == WQOS_ST_DISABLED);
   wire st_en   = (wq_state_i == WQOS_ST_ENABLED);
   wire wr_hdl  = reg_wr_i & (reg_addr_i == WQOS_OFF_HANDLE);
   wire wr_ctrl = reg_wr_i & (reg_addr_i == WQOS_OFF_CTRL);
   wire wr_stat = reg_wr_i & (reg_addr_i == WQOS_OFF_STAT);

   // Lock: limit open while disabled or while enable is clear
   wire lim_open = st_dis | ~en_ff;
   wire wr_limit = wr_ctrl & lim_open;
   wire nxt_en_w = reg_wdata_i[WQOS_BIT_EN] & occ_intr_sup_i;

   // ----------------------------------------
   // Submission handling
   // ----------------------------------------
   wire take_sub = sub_valid_i & st_en;
   wire nxt_retry = sub_valid_i & sub_is_enq_i & ~st_en;
   // Non-enqueue writes outside enabled are dropped silently
   assign occ.inc = take_sub;
   assign occ.dec = dispatch_i;

   // ----------------------------------------
   // Occupancy interrupt condition
   // ----------------------------------------
   wire [15:0] occ16 = 16'(occ.count);
   wire below = (occ16 <= limit_ff);
   wire fire  = en_ff & occ_intr_sup_i & st_en & below
                & ~gen_ff;
   // Fire follows enable the next cycle; held while not enabled
   wire clr_gen  = wr_stat & reg_wdata_i[WQOS_BIT_GEN];
   wire nxt_gen  = fire | (gen_ff & ~clr_gen);

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire [15:0] occ_rd  = occ_sup_i ? occ16 : 16'h0000;
   wire        mode_rd = ~cfg_sup_i & mode_fixed_i;
   wire [31:0] rd_hdl  = {15'h0000, tsel_ff, handle_ff};
   wire [31:0] rd_ctrl = {15'h0000, en_ff, limit_ff};
   wire [31:0] rd_stat = {wq_state_i, mode_rd, 12'h000,
                          gen_ff, occ_rd};
   wire [31:0] nxt_rdata =
      (reg_addr_i == WQOS_OFF_HANDLE) ? rd_hdl  :
      (reg_addr_i == WQOS_OFF_CTRL)   ? rd_ctrl :
      (reg_addr_i == WQOS_OFF_STAT)   ? rd_stat : 32'h0000_0000;

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         handle_ff <= WQOS_RST_HANDLE;
         tsel_ff   <= 1'b0;
      end else if (wr_hdl & st_dis) begin
         handle_ff <= reg_wdata_i[15:0];
         tsel_ff   <= reg_wdata_i[WQOS_BIT_TSEL] & occ_intr_sup_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         en_ff    <= 1'b0;
         limit_ff <= WQOS_RST_LIMIT;
      end else begin
         if (wr_ctrl) begin
            en_ff <= nxt_en_w;
         end
         if (wr_limit) begin
            limit_ff <= reg_wdata_i[15:0];
         end
      end
   end

   // ----------------------------------------
   // Status and outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         gen_ff    <= 1'b0;
         intr_ff   <= 1'b0;
         accept_ff <= 1'b0;
         retry_ff  <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rvalid_ff <= 1'b0;
      end else begin
         gen_ff    <= nxt_gen;
         intr_ff   <= fire;
         accept_ff <= take_sub;
         retry_ff  <= nxt_retry;
         rvalid_ff <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   wqos_occ_counter #(.CNT_W(CNT_W)) u_cnt (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .occ        (occ)
   );

   assign reg_rdata_o      = rdata_ff;
   assign reg_rvalid_o     = rvalid_ff;
   assign sub_accept_o     = accept_ff;
   assign sub_retry_o      = retry_ff;
   assign occ_intr_o       = intr_ff;
   assign intr_handle_o    = handle_ff;
   assign intr_table_sel_o = tsel_ff;
endmodule // wqos_top

// ==== wqos_properties.sv ====
// Checker of the queue occupancy status block
`timescale 1ns/1ps
module wqos_properties
   import wqos_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        srst_i,
   input wire logic        reg_rd_i,
   input wire logic [4:0]  reg_addr_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        reg_rvalid_o,
   input wire wqos_state_t wq_state_i,
   input wire logic        occ_intr_sup_i,
   input wire logic        cfg_sup_i,
   input wire logic        sub_valid_i,
   input wire logic        sub_is_enq_i,
   input wire logic        sub_accept_o,
   input wire logic        sub_retry_o,
   input wire logic        occ_intr_o
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   wire st_en = wq_state_i == WQOS_ST_ENABLED;
   wire rd18  = reg_rd_i && reg_addr_i == WQOS_OFF_STAT;
   a_accept_enabled: assert property (
      sub_valid_i && st_en |=> sub_accept_o)
      else $error("accept missing");
   a_retry_refused: assert property (
      sub_valid_i && sub_is_enq_i && !st_en
      |=> sub_retry_o && !sub_accept_o)
      else $error("retry missing");
   a_intr_gated: assert property (
      occ_intr_o |-> $past(wq_state_i) == WQOS_ST_ENABLED
      && $past(occ_intr_sup_i))
      else $error("interrupt while not allowed");
   a_intr_single: assert property (
      occ_intr_o |=> !occ_intr_o)
      else $error("interrupt repeated");
   a_gen_visible: assert property (
      occ_intr_o && rd18 |=> reg_rdata_o[16])
      else $error("generated bit not set");
   a_state_field: assert property (
      rd18 |=> reg_rvalid_o && reg_rdata_o[31:30] == $past(wq_state_i))
      else $error("state field wrong");
   a_mode_unused: assert property (
      rd18 && cfg_sup_i |=> !reg_rdata_o[29])
      else $error("mode bit not zero");
   a_rsvd_zero: assert property (
      rd18 |=> reg_rdata_o[28:17] == 12'h000)
      else $error("reserved status bits set");
   a_tail_zero: assert property (
      reg_rd_i && reg_addr_i == WQOS_OFF_TAIL |=> reg_rdata_o == 32'h0)
      else $error("tail word not zero");
   c_intr: cover property (occ_intr_o);
   c_gen_read: cover property (occ_intr_o && rd18);
   c_retry: cover property (sub_retry_o);
   c_accept: cover property (sub_accept_o);
endmodule // wqos_properties
bind wqos_top wqos_properties wqos_properties_i (.*);

// ==== wqos_top_tb.sv ====
// Self-checking testbench of the queue occupancy status block
`timescale 1ns/1ps
module wqos_top_tb;
   import wqos_pkg::*;
   logic clk = 0, srst = 1, wr = 0, rd = 0, sv = 0, enqueue_command_write = 0, dsp = 0;
   logic isup = 1, osup = 1, csup = 0, mfix = 1;
   logic [4:0] addr = 0;
   logic [31:0] wd = 0, rdat, q;
   logic rvld, acc, ret, intr, tsel;
   logic [15:0] hnd;
   wqos_state_t st = WQOS_ST_DISABLED;
   int failures = 0, num_checks = 0, nint = 0, nacc = 0, nret = 0;
   int cnt = 0, ns = 0, b = 0;
   wqos_top wqos_top_i (.core_clk_i(clk), .srst_i(srst), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .reg_rvalid_o(rvld), .wq_state_i(st), .occ_intr_sup_i(isup),
      .occ_sup_i(osup), .cfg_sup_i(csup), .mode_fixed_i(mfix),
      .sub_valid_i(sv), .sub_is_enq_i(enqueue_command_write), .dispatch_i(dsp),
      .sub_accept_o(acc), .sub_retry_o(ret), .occ_intr_o(intr),
      .intr_handle_o(hnd), .intr_table_sel_o(tsel));
   // ----
   // Clock, monitors and tasks
   // ----
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      if (!srst) begin
         nint += int'(intr === 1'b1);
         nacc += int'(acc === 1'b1);
         nret += int'(ret === 1'b1);
      end
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task wreg(input logic [4:0] a, input logic [31:0] d);
      addr = a;
      wd = d;
      wr = 1;
      tick(1);
      wr = 0;
   endtask
   task rreg(input logic [4:0] a);
      addr = a;
      rd = 1;
      tick(1);
      rd = 0;
      q = rdat;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   function logic [31:0] stat(input logic [1:0] s, input logic g,
                              input int c);
      return {s, ~csup & mfix, 12'h000, g, c[15:0]};
   endfunction
   task final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      final_report;
   end
   initial begin
      void'($urandom(32'h289ac719));
      tick(8);
      srst = 0;
      rreg(WQOS_OFF_STAT);
      chk("stat", stat(0, 0, 0), q);
      wreg(WQOS_OFF_TAIL, '1);
      rreg(WQOS_OFF_TAIL);
      chk("tail", 0, q);
      wreg(WQOS_OFF_HANDLE, 32'h0001ABCD);
      tick(1);
      chk("handle", 32'h1ABCD, {tsel, hnd});
      $display("test 1 done");
      wreg(WQOS_OFF_CTRL, '1);
      rreg(WQOS_OFF_CTRL);
      chk("ctrl", 32'h1FFFF, q);
      tick(4);
      chk("held", 0, nint);
      st = WQOS_ST_ENABLED;
      tick(4);
      chk("fire", 1, nint);
      rreg(WQOS_OFF_STAT);
      chk("gen", stat(1, 1, 0), q);
      wreg(WQOS_OFF_STAT, 0);
      tick(4);
      chk("once", 1, nint);
      wreg(WQOS_OFF_STAT, 32'h10000);
      tick(1);
      rreg(WQOS_OFF_STAT);
      chk("regen", stat(1, 1, 0), q);
      chk("refire", 2, nint);
      $display("test 2 done");
      wreg(WQOS_OFF_HANDLE, 32'h0);
      tick(1);
      chk("locked", 32'h1ABCD, {tsel, hnd});
      wreg(WQOS_OFF_CTRL, 0);
      tick(1);
      wreg(WQOS_OFF_STAT, 32'h10000);
      b = nacc;
      for (int i = 0; i < 40; i++) begin
         sv = i < 2 || $urandom % 3 != 0;
         enqueue_command_write = 1;
         dsp = cnt > 1 && $urandom % 4 == 0;
         cnt += int'(sv) - int'(dsp);
         ns += int'(sv);
         tick(1);
      end
      sv = 0;
      dsp = 0;
      tick(1);
      chk("acc", b + ns, nacc);
      rreg(WQOS_OFF_STAT);
      chk("count", stat(1, 0, cnt), q);
      $display("test 3 done");
      b = nint;
      wreg(WQOS_OFF_CTRL, 32'h10000 | (cnt - 1));
      tick(3);
      chk("above", b, nint);
      dsp = 1;
      tick(1);
      dsp = 0;
      cnt--;
      tick(3);
      chk("below", b + 1, nint);
      wreg(WQOS_OFF_CTRL, 32'h1FFFF);
      rreg(WQOS_OFF_CTRL);
      chk("lim lock", 32'h10000 | cnt, q);
      $display("test 4 done");
      b = nret;
      ns = nacc;
      st = WQOS_ST_DRAINING;
      sv = 1;
      tick(1);
      st = WQOS_ST_DISABLED;
      tick(1);
      enqueue_command_write = 0;
      tick(1);
      sv = 0;
      tick(2);
      chk("retry", b + 2, nret);
      chk("none", ns, nacc);
      rreg(WQOS_OFF_STAT);
      chk("kept", stat(0, 1, cnt), q);
      isup = 0;
      wreg(WQOS_OFF_CTRL, 32'h10000);
      rreg(WQOS_OFF_CTRL);
      chk("rsvd en", 0, q);
      csup = 1;
      osup = 0;
      tick(1);
      rreg(WQOS_OFF_STAT);
      chk("mode", stat(0, 1, 0), q);
      $display("test 5 done");
      final_report;
   end
endmodule // wqos_top_tb
